/* File: bench/hs_far_end.sv */
// behavioural talker and receiver standing on the pin side of the port
module hs_far_end (
    // clock
    input  wire logic        clk,
    // scenario control
    input  wire logic        talk_go,
    input  wire logic        ack_go,
    input  wire logic [3:0]  ack_delay,
    // port handshake outputs
    input  wire logic        ready_for_byte,
    input  wire logic        data_accepted,
    input  wire logic        valid_strobe_n_out,
    // lines driven toward the port, and the count of bytes sent
    output logic      [15:0] pin_data_in,
    output logic             valid_strobe_n_in,
    output logic             acknowledge_in_n,
    output logic      [7:0]  sent_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // talker: bytes a0, a1, ... each behind a full three-wire cycle
    initial begin
        int n;
        valid_strobe_n_in = 1'b1;
        pin_data_in       = 16'h0000;
        sent_count        = 8'h00;
        forever begin
            @(posedge clk);
            if (talk_go && ready_for_byte) begin
                pin_data_in <= {8'h00, 8'ha0 + sent_count};
                @(posedge clk);
                valid_strobe_n_in <= 1'b0;
                for (n = 0; n < 50 && !data_accepted; n++) @(posedge clk);
                valid_strobe_n_in <= 1'b1;
                // released data is not held: show its inverse
                pin_data_in <= ~pin_data_in;
                // a byte counts only once its acceptance was seen
                if (n < 50) begin
                    sent_count <= sent_count + 8'h01;
                end
                for (n = 0; n < 50 && data_accepted; n++) @(posedge clk);
            end
        end
    end

    // receiver: takes the byte by a falling acknowledge after a delay
    initial begin
        acknowledge_in_n = 1'b1;
        forever begin
            @(posedge clk);
            if (ack_go && !valid_strobe_n_out) begin
                repeat (ack_delay) @(posedge clk);
                acknowledge_in_n <= 1'b0;
                repeat (6) @(posedge clk);
                acknowledge_in_n <= 1'b1;
                repeat (2) @(posedge clk);
            end
        end
    end
endmodule

/* File: bench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk, reset_n, data_wr, clear_ip_cmd;
    logic                     rd_valid, rd_ready, oe_n, vs_in_n, vs_out_n;
    logic                     ready_for_byte, data_accepted, ack_n;
    logic                     talk_go, ack_go;
    logic [3:0]               ack_delay;
    logic [7:0]               sent_count;
    logic [15:0]              pin_data_in;
    hsport_pkg::port_config_t cfg;
    hsport_pkg::word_t        data_wr_val, rd_data, buffer_view, pin_data_out;
    hsport_pkg::port_status_t status;
    int                       err_count, check_count;

    handshake_parallel_port i_dut (
        .clk(clk), .reset_n(reset_n), .cfg(cfg), .data_wr(data_wr),
        .data_wr_val(data_wr_val), .clear_ip_cmd(clear_ip_cmd),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .status(status), .buffer_view(buffer_view),
        .pin_data_in(pin_data_in), .pin_data_out(pin_data_out),
        .pin_data_oe_n(oe_n), .valid_strobe_n_in(vs_in_n),
        .valid_strobe_n_out(vs_out_n), .ready_for_byte(ready_for_byte),
        .data_accepted(data_accepted), .acknowledge_in_n(ack_n)
    );

    hs_far_end i_far (
        .clk(clk), .talk_go(talk_go), .ack_go(ack_go), .ack_delay(ack_delay),
        .ready_for_byte(ready_for_byte), .data_accepted(data_accepted),
        .valid_strobe_n_out(vs_out_n), .pin_data_in(pin_data_in),
        .valid_strobe_n_in(vs_in_n), .acknowledge_in_n(ack_n),
        .sent_count(sent_count)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic print_verdict;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic bound_hit(input int n, input int lim);
        if (n >= lim) begin
            err_count++;
            $display("unexpected at %0t: wait bound %h reached", $time, lim);
            print_verdict();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // fields: enables, direction, linked, single buffer, two-byte irq
    task automatic do_reset(input logic [5:0] c);
        reset_n <= 1'b0;
        cfg     <= c;
        cyc(20);
        reset_n <= 1'b1;
        cyc(2);
    endtask

    task automatic wr(input logic [15:0] v);
        data_wr     <= 1'b1;
        data_wr_val <= v;
        @(posedge clk);
        data_wr     <= 1'b0;
        cyc(4);
    endtask

    // one acknowledge from the receiver, then let the flags settle
    task automatic one_ack(input logic [3:0] d);
        int n;
        ack_delay <= d;
        ack_go    <= 1'b1;
        for (n = 0; n < 100 && ack_n !== 1'b0; n++) @(posedge clk);
        bound_hit(n, 100);
        ack_go <= 1'b0;
        cyc(16);
    endtask

    // fill fifo and buffer until ready stays low, then drain in order
    task automatic scen_input;
        int n;
        do_reset(6'b100000);
        talk_go <= 1'b1;
        for (n = 0; n < 3000 && sent_count < 8'h09; n++) @(posedge clk);
        bound_hit(n, 3000);
        cyc(80);
        talk_go <= 1'b0;
        check(sent_count, 16'h0009);
        check(ready_for_byte, 1'b0);
        check(status.input_full_flag, 1'b1);
        for (int i = 0; i < 9; i++) begin
            for (n = 0; n < 50 && rd_valid !== 1'b1; n++) @(posedge clk);
            bound_hit(n, 50);
            check(rd_data, {8'h00, 8'ha0 + 8'(i)});
            rd_ready <= 1'b1;
            @(posedge clk);
            rd_ready <= 1'b0;
            @(posedge clk);
        end
        cyc(10);
        check(ready_for_byte, 1'b1);
        check(data_accepted, 1'b0);
        check(status.input_full_flag, 1'b0);
    endtask

    task automatic scen_double;
        do_reset(6'b101000);
        cyc(5);
        check(status.interrupt_pending_flag, 1'b0);
        check(status.input_full_flag, 1'b0);
        wr(16'hc35a);
        check(status.output_empty_flag, 1'b1);
        check(status.interrupt_pending_flag, 1'b1);
        check(vs_out_n, 1'b0);
        check(pin_data_out, 16'h005a);
        check(rd_data, 16'h005a);
        check(rd_valid, 1'b1);
        check(oe_n, 1'b0);
        clear_ip_cmd <= 1'b1;
        @(posedge clk);
        clear_ip_cmd <= 1'b0;
        cyc(3);
        check(status.interrupt_pending_flag, 1'b0);
        check(status.output_empty_flag, 1'b1);
        wr(16'h00a5);
        check(status.output_empty_flag, 1'b0);
        check(status.buffer_full, 1'b1);
        one_ack(4'h1);
        check(pin_data_out, 16'h00a5);
        check(status.interrupt_pending_flag, 1'b1);
        check(status.output_empty_flag, 1'b1);
        one_ack(4'h5);
        check(status.buffer_full, 1'b0);
        check(vs_out_n, 1'b1);
    endtask

    task automatic scen_two_byte;
        do_reset(6'b101001);
        wr(16'h0011);
        check(status.output_empty_flag, 1'b1);
        check(status.interrupt_pending_flag, 1'b0);
        wr(16'h0022);
        one_ack(4'h2);
        check(pin_data_out, 16'h0022);
        check(status.interrupt_pending_flag, 1'b0);
        one_ack(4'h2);
        check(status.interrupt_pending_flag, 1'b1);
        wr(16'h0033);
        check(status.interrupt_pending_flag, 1'b1);
        wr(16'h0044);
        check(status.interrupt_pending_flag, 1'b0);
        check(status.output_empty_flag, 1'b0);
    endtask

    task automatic scen_single;
        do_reset(6'b101010);
        wr(16'h003c);
        check(status.buffer_full, 1'b1);
        check(status.output_empty_flag, 1'b0);
        one_ack(4'h3);
        check(status.output_empty_flag, 1'b1);
        check(status.interrupt_pending_flag, 1'b1);
        check(status.buffer_full, 1'b0);
        wr(16'h00c3);
        check(status.interrupt_pending_flag, 1'b0);
        check(pin_data_out, 16'h00c3);
    endtask

    task automatic scen_linked;
        do_reset(6'b111100);
        wr(16'hbeef);
        check(pin_data_out, 16'hbeef);
        check(buffer_view, 16'hbeef);
    endtask

    initial begin
        reset_n      = 1'b0;
        cfg          = '0;
        data_wr      = 1'b0;
        data_wr_val  = 16'h0000;
        clear_ip_cmd = 1'b0;
        rd_ready     = 1'b0;
        talk_go      = 1'b0;
        ack_go       = 1'b0;
        ack_delay    = 4'h2;
        err_count    = 0;
        check_count  = 0;
        scen_input();
        scen_double();
        scen_two_byte();
        scen_single();
        scen_linked();
        print_verdict();
    end

    // run-length guard
    initial begin
        #2000000;
        err_count++;
        $display("unexpected at %0t: run bound %h reached", $time, 1);
        print_verdict();
    end
endmodule

/* File: rtl/handshake_parallel_port.sv */
// Summary of operation
// [RULE_01] listener ready and accepted lines are wired-and across listeners
// [RULE_02] talker lowers valid strobe only after combined ready is high
// [RULE_03] valid strobe fall latches pin data and drops ready
// [RULE_04] listener releases accepted high after taking the byte
// [RULE_05] talker raises valid strobe only after combined accepted is high
// [RULE_06] strobe high drops accepted; ready returns once buffer is empty
// [RULE_07] output direction holds input-full flag at zero
// [RULE_08] output transfers 8 bits, or 16 bits when ports are linked
// [RULE_09] double-buffered: data moves to empty buffer, sets output-empty
// [RULE_10] acknowledge fall marks output buffer empty
// [RULE_11] output direction: input data read returns buffer register
// [RULE_12] valid strobe low only while output byte is valid
// [RULE_13] one-byte interrupts: pending set with output-empty on move
// [RULE_14] data write fills register, clears pending and output-empty
// [RULE_15] clear command clears pending without filling the register
// [RULE_16] enabling without any write never sets pending
// [RULE_17] two-byte interrupts: pending when buffer and register both empty
// [RULE_18] two-byte interrupts: second write clears pending
// [RULE_19] software writes only while pending under two-byte interrupts
// [RULE_20] single-buffered: copy stays in data register, still full
// [RULE_21] single-buffered: ack fall empties both, sets empty and pending
// [RULE_22] software selects one-byte interrupts when single-buffered
// [RULE_23] ready rises only with buffer empty and strobe high
// [RULE_24] accepted forced low as soon as strobe returns high
// [RULE_25] handshake inputs synchronised; edges found on synchronised samples
`include "hsport_defines.svh"
module handshake_parallel_port (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // configuration
    input  wire hsport_pkg::port_config_t   cfg,
    // cpu data write
    input  wire logic                       data_wr,
    input  wire hsport_pkg::word_t          data_wr_val,
    input  wire logic                       clear_ip_cmd,
    // cpu input data read stream
    output logic                            rd_valid,
    input  wire logic                       rd_ready,
    output hsport_pkg::word_t               rd_data,
    // status
    output hsport_pkg::port_status_t        status,
    output hsport_pkg::word_t               buffer_view,
    // pins
    input  wire logic [15:0]                pin_data_in,
    output hsport_pkg::word_t               pin_data_out,
    output logic                            pin_data_oe_n,
    input  wire logic                       valid_strobe_n_in,
    output logic                            valid_strobe_n_out,
    output logic                            ready_for_byte,
    output logic                            data_accepted,
    input  wire logic                       acknowledge_in_n
);

    logic               strobe_s;
    logic               ack_s;
    logic [15:0]        pins_s;
    logic               strobe_d_r;
    logic               ack_d_r;
    logic               strobe_fall;
    logic               ack_fall;
    logic               out_mode;
    logic               en;
    logic [15:0]        wmask;

    // input path state
    hsport_pkg::listen_state_t ls_r;
    hsport_pkg::listen_state_t ls_nxt;
    hsport_pkg::word_t  ibuf_r;
    hsport_pkg::word_t  ibuf_nxt;
    logic               ibuf_full_r;
    logic               ibuf_full_nxt;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    hsport_pkg::word_t  fifo_out_data;

    // output path state
    hsport_pkg::word_t  odr_r;
    hsport_pkg::word_t  odr_nxt;
    logic               odr_full_r;
    logic               odr_full_nxt;
    hsport_pkg::word_t  obuf_r;
    hsport_pkg::word_t  obuf_nxt;
    logic               obuf_full_r;
    logic               obuf_full_nxt;
    logic               ip_r;
    logic               ip_nxt;
    logic               wrote_once_r;
    logic               wrote_once_nxt;

    hs_sync #(.WIDTH(18)) u_sync (                       // RULE_25
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({valid_strobe_n_in, acknowledge_in_n, pin_data_in}),
        .sync_out ({strobe_s, ack_s, pins_s})
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_d_r <= 1'b1;
            ack_d_r    <= 1'b1;
        end else begin
            strobe_d_r <= strobe_s;
            ack_d_r    <= ack_s;
        end
    end

    assign strobe_fall = strobe_d_r && !strobe_s;         // RULE_25
    assign ack_fall    = ack_d_r && !ack_s;
    assign out_mode    = (cfg.dir_output == `HS_DIR_OUTPUT);
    assign en          = cfg.first_port_enable || cfg.second_port_enable;
    assign wmask       = cfg.linked ? 16'hffff : 16'h00ff; // RULE_08

    // three-wire listener
    always_comb begin
        ls_nxt        = ls_r;
        ibuf_nxt      = ibuf_r;
        ibuf_full_nxt = ibuf_full_r;
        if (ibuf_full_r && fifo_in_ready) begin
            ibuf_full_nxt = 1'b0;
        end
        unique case (ls_r)
            hsport_pkg::LS_IDLE: begin
                if (strobe_fall && en && !out_mode && !ibuf_full_r) begin
                    ibuf_nxt      = pins_s & wmask;       // RULE_03
                    ibuf_full_nxt = 1'b1;
                    ls_nxt        = hsport_pkg::LS_TAKEN;
                end
            end
            hsport_pkg::LS_TAKEN: begin
                if (strobe_s) begin
                    ls_nxt = hsport_pkg::LS_IDLE;         // RULE_24
                end else begin
                    ls_nxt = hsport_pkg::LS_WAIT;
                end
            end
            hsport_pkg::LS_WAIT: begin
                if (strobe_s) begin
                    ls_nxt = hsport_pkg::LS_IDLE;         // RULE_06
                end
            end
            default: ls_nxt = hsport_pkg::LS_IDLE;
        endcase
        if (out_mode) begin
            ls_nxt = hsport_pkg::LS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ls_r        <= hsport_pkg::LS_IDLE;
            ibuf_r      <= '0;
            ibuf_full_r <= 1'b0;
        end else begin
            ls_r        <= ls_nxt;
            ibuf_r      <= ibuf_nxt;
            ibuf_full_r <= ibuf_full_nxt;
        end
    end

    // accepted rises once the byte is latched; open-collector style wired-and
    assign data_accepted  = !out_mode                // RULE_04 RULE_01
                            && (ls_r == hsport_pkg::LS_WAIT);
    assign ready_for_byte = !out_mode && en && !ibuf_full_r && strobe_s
                            && (ls_r == hsport_pkg::LS_IDLE); // RULE_23

    hs_fifo #(
        .WIDTH (16),
        .DEPTH (`HS_FIFO_DEPTH),
        .AW    (`HS_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (ibuf_full_r),
        .in_ready  (fifo_in_ready),
        .in_data   (ibuf_r),
        .out_valid (fifo_out_valid),
        .out_ready (rd_ready && !out_mode),
        .out_data  (fifo_out_data)
    );

    // output data path
    always_comb begin
        odr_nxt        = odr_r;
        odr_full_nxt   = odr_full_r;
        obuf_nxt       = obuf_r;
        obuf_full_nxt  = obuf_full_r;
        ip_nxt         = ip_r;
        wrote_once_nxt = wrote_once_r;
        if (!out_mode) begin
            ip_nxt = 1'b0;
        end else begin
            // a hardware set in the same cycle wins over the clear
            if (clear_ip_cmd) begin
                ip_nxt = 1'b0;                            // RULE_15
            end
            if (ack_fall && obuf_full_r) begin
                obuf_full_nxt = 1'b0;                     // RULE_10
                if (cfg.single_buffer_select) begin
                    odr_full_nxt = 1'b0;                  // RULE_21
                    ip_nxt       = 1'b1;
                end else if (cfg.two_byte_interrupt_select && !odr_full_r) begin
                    ip_nxt = 1'b1;                        // RULE_17
                end
            end else if (en && odr_full_r && !obuf_full_r) begin
                obuf_nxt      = odr_r;
                obuf_full_nxt = 1'b1;
                if (!cfg.single_buffer_select) begin
                    odr_full_nxt = 1'b0;                  // RULE_09
                    if (!cfg.two_byte_interrupt_select) begin
                        ip_nxt = 1'b1;                    // RULE_13 RULE_16
                    end
                end                                       // RULE_20
            end
            if (data_wr) begin
                odr_nxt        = data_wr_val & wmask;     // RULE_08
                odr_full_nxt   = 1'b1;                    // RULE_14
                // two-byte mode: only the write behind a held byte clears
                if (!cfg.two_byte_interrupt_select || obuf_full_r) begin
                    ip_nxt     = 1'b0;                    // RULE_14 RULE_18
                end
                wrote_once_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            odr_r        <= '0;
            odr_full_r   <= 1'b0;
            obuf_r       <= '0;
            obuf_full_r  <= 1'b0;
            ip_r         <= 1'b0;
            wrote_once_r <= 1'b0;
        end else begin
            odr_r        <= odr_nxt;
            odr_full_r   <= odr_full_nxt;
            obuf_r       <= obuf_nxt;
            obuf_full_r  <= obuf_full_nxt;
            ip_r         <= ip_nxt;
            wrote_once_r <= wrote_once_nxt;
        end
    end

    assign pin_data_out       = obuf_r;
    assign pin_data_oe_n      = !out_mode;
    assign valid_strobe_n_out = !(out_mode && obuf_full_r); // RULE_12
    assign buffer_view        = out_mode ? obuf_r : fifo_out_data; // RULE_11
    assign rd_data            = out_mode ? obuf_r : fifo_out_data; // RULE_11
    assign rd_valid           = out_mode ? 1'b1 : fifo_out_valid;

    assign status.output_empty_flag      = !odr_full_r;
    assign status.interrupt_pending_flag = ip_r;
    assign status.buffer_full            = out_mode ? obuf_full_r : ibuf_full_r;
    assign status.input_full_flag        = out_mode ? 1'b0    // RULE_07
                                                    : fifo_out_valid;

    // assertions
    chk_input_full_zero: assert property (      // RULE_07
        @(posedge clk) disable iff (!reset_n)
        out_mode |-> !status.input_full_flag)
        else $error("input full flag set in output mode");

    chk_strobe_latch: assert property (         // RULE_03
        @(posedge clk) disable iff (!reset_n)
        (strobe_fall && en && !out_mode && !ibuf_full_r
         && ls_r == hsport_pkg::LS_IDLE)
        |=> (ibuf_full_r && !ready_for_byte))
        else $error("strobe fall did not latch byte");

    chk_accept_drop: assert property (          // RULE_24
        @(posedge clk) disable iff (!reset_n)
        (data_accepted && strobe_s) |=> !data_accepted)
        else $error("accepted not dropped after strobe rise");

    chk_ready_cond: assert property (           // RULE_23
        @(posedge clk) disable iff (!reset_n)
        ready_for_byte |-> (strobe_s && !ibuf_full_r))
        else $error("ready high with buffer full or strobe low");

    sequence s_taken;
        ls_r == hsport_pkg::LS_TAKEN && !strobe_s;
    endsequence
    chk_accept_rise: assert property (          // RULE_04
        @(posedge clk) disable iff (!reset_n)
        s_taken |=> data_accepted)
        else $error("accepted not released");

    chk_strobe_valid: assert property (         // RULE_12
        @(posedge clk) disable iff (!reset_n)
        !valid_strobe_n_out |-> obuf_full_r)
        else $error("strobe low without valid byte");

    chk_ack_empty: assert property (            // RULE_10
        @(posedge clk) disable iff (!reset_n)
        (out_mode && ack_fall && obuf_full_r) |=> !obuf_full_r)
        else $error("ack fall did not empty buffer");

    chk_write_fill: assert property (           // RULE_14
        @(posedge clk) disable iff (!reset_n)
        (out_mode && data_wr
         && (!cfg.two_byte_interrupt_select || obuf_full_r))
        |=> (!status.output_empty_flag && !ip_r))
        else $error("write did not fill register");

    chk_clear_cmd: assert property (            // RULE_15
        @(posedge clk) disable iff (!reset_n)
        (out_mode && clear_ip_cmd && !data_wr) |=>
        (!ip_r && $stable(odr_full_r) || !odr_full_r))
        else $error("clear command misbehaved");

    chk_one_byte_ip: assert property (          // RULE_13
        @(posedge clk) disable iff (!reset_n)
        (out_mode && en && !cfg.single_buffer_select
         && !cfg.two_byte_interrupt_select && odr_full_r && !obuf_full_r
         && !ack_fall && !data_wr && !clear_ip_cmd) |=>
        (ip_r && status.output_empty_flag))
        else $error("move did not set pending");

    chk_never_written: assert property (        // RULE_16
        @(posedge clk) disable iff (!reset_n)
        (out_mode && !wrote_once_r && !cfg.single_buffer_select) |-> !ip_r)
        else $error("pending without any write");

    chk_single_copy: assert property (          // RULE_20
        @(posedge clk) disable iff (!reset_n)
        (out_mode && en && cfg.single_buffer_select && odr_full_r
         && !obuf_full_r && !ack_fall) |=> (obuf_full_r && odr_full_r))
        else $error("single buffer lost its copy");

endmodule

/* File: rtl/hs_fifo.sv */
module hs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    wp_nxt;
    logic [AW-1:0]    rp_r;
    logic [AW-1:0]    rp_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rp_r];

    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

endmodule

/* File: rtl/hs_sync.sv */
module hs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // raw and synchronised levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

/* File: rtl/hsport_defines.svh */
`ifndef HSPORT_DEFINES_SVH
`define HSPORT_DEFINES_SVH

// data path widths
`define HS_BYTE_W      8
`define HS_WORD_W      16
// input fifo toward the cpu
`define HS_FIFO_DEPTH  8
`define HS_FIFO_AW     3
// port direction encoding
`define HS_DIR_INPUT   1'b0
`define HS_DIR_OUTPUT  1'b1

`endif

/* File: rtl/hsport_pkg.sv */
package hsport_pkg;

    typedef logic [15:0] word_t;

    // output- and input-side status seen by the cpu
    typedef struct packed {
        logic output_empty_flag;
        logic interrupt_pending_flag;
        logic buffer_full;
        logic input_full_flag;
    } port_status_t;

    // port configuration
    typedef struct packed {
        logic first_port_enable;
        logic second_port_enable;
        logic dir_output;
        logic linked;
        logic single_buffer_select;
        logic two_byte_interrupt_select;
    } port_config_t;

    typedef enum logic [1:0] {
        LS_IDLE   = 2'b00,
        LS_TAKEN  = 2'b01,
        LS_WAIT   = 2'b10
    } listen_state_t;

endpackage
